/* rtl/dmahub_pkg.sv */
`default_nettype none
// What this block does
// - two masters, CPU and DMA, start independently
// - eight parallel spokes, fixed peripheral groups
// - CPU and DMA concurrent on different spokes
// - DMA read and write overlap across spokes
// - 8/16/24/32-bit data widths, 32-bit addresses
// - 24 channels, shared 128-descriptor pool
// - descriptors writable live, chainable
// - eight priority levels, zero is highest
// - trigger by pin, CPU or chained channel
// - at most two events per transfer
// - channel stall, resume and cancel
// - length infinite or 1 to 64 KB
// - CPU wins shared spoke over DMA
// - CPU can never starve DMA
// - preemption only between transactions
// - fair slot shares for levels 2-7
// - levels 0 and 1 outside fairness
// - round robin within one level
// - per-channel round robin opt-out wins ties
// - fairness off: strict priority only
// - one descriptor moves source to sink
// - boot configuration writes through hub
package dmahub_pkg;
  localparam int NUM_CH = 24;
  localparam int CH_W = 5;
  localparam int NUM_TD = 128;
  localparam int TD_W = 7;
  localparam int NUM_LVL = 8;
  localparam int LVL_W = 3;
  localparam int SPOKE_W = 3;
  localparam int SPOKE_LSB = 29;
  localparam int REM_W = 17;
  localparam int LEN_W = 16;
  localparam int SLOT_W = 6;
  localparam logic [LVL_W-1:0] FAIR_LVL_LO = 3'h2;
  localparam logic [1:0] STARVE_LIMIT = 2'h3;
  localparam logic [1:0] SIZE_WORD = 2'h3;
  // ==========================================
  // register map
  localparam logic [11:0] REG_CTRL = 12'h000;
  localparam logic [11:0] REG_CHSEL = 12'h004;
  localparam logic [11:0] REG_CHCFG = 12'h008;
  localparam logic [11:0] REG_CHCMD = 12'h00C;
  localparam logic [11:0] REG_TDSEL = 12'h010;
  localparam logic [11:0] REG_TDSRC = 12'h014;
  localparam logic [11:0] REG_TDDST = 12'h018;
  localparam logic [11:0] REG_TDCTL = 12'h01C;
  localparam logic [11:0] REG_STATUS = 12'h020;
  localparam int CTRL_EN = 0;
  localparam int CTRL_FAIR = 1;
  localparam int CFG_PRIO = 0;
  localparam int CFG_RRDIS = 3;
  localparam int CFG_TD = 4;
  localparam int CFG_EN = 11;
  localparam int CFG_CHAIN = 12;
  localparam int CFG_CHAIN_EN = 17;
  localparam int CFG_DONE_IRQ = 18;
  localparam int CFG_W = 19;
  localparam int ST_RUN = 24;
  localparam int ST_STALL = 25;
  localparam int CMD_TRIG = 0;
  localparam int CMD_STALL = 1;
  localparam int CMD_RESUME = 2;
  localparam int CMD_CANCEL = 3;
  localparam int TDC_LEN = 0;
  localparam int TDC_INF = 16;
  localparam int TDC_NEXT = 17;
  localparam int TDC_CHAIN = 24;
  localparam int TDC_IRQ = 25;
  localparam int TDC_WID = 26;
  localparam int TDC_W = 28;

  function automatic logic [SPOKE_W-1:0] spokeOf(input logic [31:0] a);
    return a[SPOKE_LSB +: SPOKE_W];
  endfunction
endpackage
`default_nettype wire

/* rtl/dmahub_spoke_arb.sv */
`timescale 1ns/100ps
`default_nettype none
module dmahub_spoke_arb import dmahub_pkg::*; (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic cpuReq,
  input wire logic [SPOKE_W-1:0] cpuSpoke,
  input wire logic rdReq,
  input wire logic [SPOKE_W-1:0] rdSpoke,
  input wire logic wrReq,
  input wire logic [SPOKE_W-1:0] wrSpoke,
  output logic cpuGnt,
  output logic rdGo,
  output logic wrGo
);
  typedef struct packed {
    logic [1:0] wait_;
  } dmahub_sarb_t;
  dmahub_sarb_t s_q, s_d;
  logic rdHit, wrHit, dmaTurn;

  always_comb begin
    s_d = s_q;
    rdHit = rdReq && cpuReq && (rdSpoke == cpuSpoke);
    wrHit = wrReq && cpuReq && (wrSpoke == cpuSpoke);
    // bounded wait: after a few lost cycles the DMA takes the spoke once
    dmaTurn = (s_q.wait_ == STARVE_LIMIT);
    cpuGnt = cpuReq && !(dmaTurn && (rdHit || wrHit));
    // other spokes proceed in parallel with the cpu
    wrGo = wrReq && !(cpuGnt && wrSpoke == cpuSpoke);
    rdGo = rdReq && !(cpuGnt && rdSpoke == cpuSpoke)
      && !(wrGo && rdSpoke == wrSpoke);
    s_d.wait_ = (cpuGnt && (rdHit || wrHit)) ? s_q.wait_ + 2'h1 : 2'h0;
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end
endmodule
`default_nettype wire

/* rtl/dmahub_ch_arb.sv */
`timescale 1ns/100ps
`default_nettype none
module dmahub_ch_arb import dmahub_pkg::*; (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic [NUM_CH-1:0] chReq,
  input wire logic [NUM_CH*LVL_W-1:0] chPrio,
  input wire logic [NUM_CH-1:0] chRrDis,
  input wire logic fairEn,
  input wire logic taken,
  output logic winValid,
  output logic [CH_W-1:0] winCh
);
  typedef struct packed {
    logic [NUM_LVL-1:0][CH_W-1:0] rrPtr;
    logic [SLOT_W-1:0] slot;
  } dmahub_carb_t;
  dmahub_carb_t s_q, s_d;
  logic [NUM_LVL-1:0] lvlReq;
  logic [LVL_W-1:0] lvl, pref;
  logic [CH_W-1:0] idx;
  logic picked;

  function automatic logic [CH_W-1:0] nextCh(input logic [CH_W-1:0] c);
    return (c == CH_W'(NUM_CH - 1)) ? '0 : c + 5'h01;
  endfunction

  always_comb begin
    s_d = s_q;
    lvlReq = '0;
    pref = LVL_W'(NUM_LVL - 1);
    lvl = '0;
    winValid = 1'b0;
    winCh = '0;
    picked = 1'b0;
    for (int c = 0; c < NUM_CH; c++) begin
      if (chReq[c]) begin
        lvlReq[chPrio[c*LVL_W +: LVL_W]] = 1'b1;
      end
    end
    // lowest set slot bit picks the level: 1/2, 1/4 ... of fair slots
    for (int k = SLOT_W - 1; k >= 0; k--) begin
      if (s_q.slot[k]) begin
        pref = FAIR_LVL_LO + LVL_W'(k);
      end
    end
    for (int l = NUM_LVL - 1; l >= 0; l--) begin
      if (lvlReq[l]) begin
        lvl = LVL_W'(l);
        winValid = 1'b1;
      end
    end
    // levels 0 and 1 are never diverted by the schedule
    if (fairEn && lvl >= FAIR_LVL_LO && lvlReq[pref]) begin
      lvl = pref;
    end
    idx = s_q.rrPtr[lvl];
    for (int i = 0; i < NUM_CH; i++) begin
      if (!picked && chReq[idx] && chPrio[idx*LVL_W +: LVL_W] == lvl) begin
        winCh = idx;
        picked = 1'b1;
      end
      idx = nextCh(idx);
    end
    for (int c = NUM_CH - 1; c >= 0; c--) begin
      if (chReq[c] && chRrDis[c] && chPrio[c*LVL_W +: LVL_W] == lvl) begin
        winCh = CH_W'(c);
      end
    end
    if (taken && winValid) begin
      s_d.rrPtr[lvl] = nextCh(winCh);
      if (fairEn && lvl >= FAIR_LVL_LO) begin
        s_d.slot = s_q.slot + 6'h01;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end
endmodule
`default_nettype wire

/* rtl/dmahub_top.sv */
// Added by the designer: the register offsets and the APB slave port.
`timescale 1ns/100ps
`default_nettype none
module dmahub_top import dmahub_pkg::*; (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic cpuReq,
  input wire logic [SPOKE_W-1:0] cpuSpoke,
  output logic cpuGnt,
  output logic dmaRdValid,
  output logic [31:0] dmaRdAddr,
  output logic [1:0] dmaRdSize,
  input wire logic dmaRdReady,
  input wire logic [31:0] dmaRdData,
  output logic dmaWrValid,
  output logic [31:0] dmaWrAddr,
  output logic [1:0] dmaWrSize,
  output logic [31:0] dmaWrData,
  input wire logic dmaWrReady,
  input wire logic bootWrValid,
  input wire logic [31:0] bootWrAddr,
  input wire logic [31:0] bootWrData,
  output logic bootWrReady,
  input wire logic [NUM_CH-1:0] trigIn,
  output logic evTdDone,
  output logic evChDone,
  output logic [CH_W-1:0] evChan
);
  // ==========================================
  // state
  typedef struct packed {
    logic en;
    logic fair;
    logic [CH_W-1:0] chSel;
    logic [TD_W-1:0] tdSel;
    logic [NUM_CH-1:0] run;
    logic [NUM_CH-1:0] stall;
    logic [NUM_CH-1:0] trgS1;
    logic [NUM_CH-1:0] trgS2;
    logic [NUM_CH-1:0] trgS3;
    logic rdPend;
    logic [31:0] rdAddr;
    logic [31:0] rdDst;
    logic [1:0] rdSize;
    logic holdFull;
    logic [31:0] wrAddr;
    logic [31:0] wrData;
    logic [1:0] wrSize;
    logic [CH_W-1:0] lastCh;
    logic [31:0] prdata;
    logic slvErr;
    logic evTd;
    logic evDone;
    logic [CH_W-1:0] evChan;
  } dmahub_eng_t;
  dmahub_eng_t s_q, s_d;

  // descriptor pool and per-channel live context
  logic [31:0] tdSrc [NUM_TD];
  logic [31:0] tdDst [NUM_TD];
  logic [TDC_W-1:0] tdCtl [NUM_TD];
  logic [CFG_W-1:0] chCfg [NUM_CH];
  logic [TD_W-1:0] ctxTd [NUM_CH];
  logic [31:0] ctxSrc [NUM_CH];
  logic [31:0] ctxDst [NUM_CH];
  logic [REM_W-1:0] ctxRem [NUM_CH];

  logic apbSetup, apbWr, cfgWr, wrTdSrc, wrTdDst, wrTdCtl;
  logic [3:0] cmd;
  logic [31:0] rdMux;
  logic mapped;
  logic [NUM_CH-1:0] chReqV, chRrDis, start, hwEdge, swTrig, chainVec;
  logic [NUM_CH*LVL_W-1:0] chPrio;
  logic winValid, issue, rdGo, wrGo, rdFire, wrFire;
  logic [CH_W-1:0] w;
  logic [TDC_W-1:0] ctl;
  logic [2:0] bytes, n;
  logic inf, last, chainLoad;
  logic [TD_W-1:0] nextTd;

  function automatic logic [REM_W-1:0] remInit(input logic [TDC_W-1:0] c);
    return REM_W'(c[TDC_LEN +: LEN_W]) + 17'h0_0001;
  endfunction

  function automatic logic [NUM_CH-1:0] oneHot(input logic [CH_W-1:0] c);
    logic [NUM_CH-1:0] v;
    v = '0;
    v[c] = 1'b1;
    return v;
  endfunction

  // ==========================================
  // arbiters
  always_comb begin
    for (int c = 0; c < NUM_CH; c++) begin
      chPrio[c*LVL_W +: LVL_W] = chCfg[c][CFG_PRIO +: LVL_W];
      chRrDis[c] = chCfg[c][CFG_RRDIS];
      chReqV[c] = s_q.run[c] && !s_q.stall[c] && chCfg[c][CFG_EN];
    end
  end

  dmahub_ch_arb u_charb (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .chReq(chReqV),
    .chPrio(chPrio),
    .chRrDis(chRrDis),
    .fairEn(s_q.fair),
    .taken(issue),
    .winValid(winValid),
    .winCh(w)
  );

  // boot writes take the hold slot ahead of channel reads
  dmahub_spoke_arb u_sparb (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .cpuReq(cpuReq),
    .cpuSpoke(cpuSpoke),
    .rdReq(s_q.rdPend && !bootWrValid),
    .rdSpoke(spokeOf(s_q.rdAddr)),
    .wrReq(s_q.holdFull),
    .wrSpoke(spokeOf(s_q.wrAddr)),
    .cpuGnt(cpuGnt),
    .rdGo(rdGo),
    .wrGo(wrGo)
  );

  // ==========================================
  // bus side handshakes
  always_comb begin
    dmaWrValid = wrGo;
    // a read may land while the held beat leaves in the same cycle
    dmaRdValid = rdGo && (!s_q.holdFull || (wrGo && dmaWrReady));
    rdFire = dmaRdValid && dmaRdReady;
    wrFire = dmaWrValid && dmaWrReady;
    bootWrReady = !s_q.holdFull;
    dmaRdAddr = s_q.rdAddr;
    dmaRdSize = s_q.rdSize;
    dmaWrAddr = s_q.wrAddr;
    dmaWrData = s_q.wrData;
    dmaWrSize = s_q.wrSize;
    prdata = s_q.prdata;
    pready = 1'b1;
    pslverr = s_q.slvErr;
    evTdDone = s_q.evTd;
    evChDone = s_q.evDone;
    evChan = s_q.evChan;
  end

  // ==========================================
  // register decode, triggers and beat issue
  always_comb begin
    s_d = s_q;
    s_d.evTd = 1'b0;
    s_d.evDone = 1'b0;
    s_d.trgS1 = trigIn;
    s_d.trgS2 = s_q.trgS1;
    s_d.trgS3 = s_q.trgS2;
    apbSetup = psel && !penable;
    apbWr = psel && penable && pwrite;
    cfgWr = 1'b0;
    wrTdSrc = 1'b0;
    wrTdDst = 1'b0;
    wrTdCtl = 1'b0;
    cmd = '0;
    mapped = 1'b1;
    rdMux = '0;
    case (paddr)
      REG_CTRL: begin
        rdMux[CTRL_EN] = s_q.en;
        rdMux[CTRL_FAIR] = s_q.fair;
      end
      REG_CHSEL: rdMux[CH_W-1:0] = s_q.chSel;
      REG_CHCFG: begin
        rdMux[CFG_W-1:0] = chCfg[s_q.chSel];
        rdMux[ST_RUN] = s_q.run[s_q.chSel];
        rdMux[ST_STALL] = s_q.stall[s_q.chSel];
      end
      REG_CHCMD: rdMux = '0;
      REG_TDSEL: rdMux[TD_W-1:0] = s_q.tdSel;
      REG_TDSRC: rdMux = tdSrc[s_q.tdSel];
      REG_TDDST: rdMux = tdDst[s_q.tdSel];
      REG_TDCTL: rdMux[TDC_W-1:0] = tdCtl[s_q.tdSel];
      REG_STATUS: rdMux = {23'h00_0000, s_q.lastCh, s_q.holdFull, s_q.rdPend,
        s_q.fair, s_q.en};
      default: mapped = 1'b0;
    endcase
    if (apbSetup) begin
      s_d.prdata = rdMux;
      s_d.slvErr = !mapped;
    end
    if (apbWr) begin
      case (paddr)
        REG_CTRL: begin
          s_d.en = pwdata[CTRL_EN];
          s_d.fair = pwdata[CTRL_FAIR];
        end
        REG_CHSEL: s_d.chSel = pwdata[CH_W-1:0];
        REG_CHCFG: cfgWr = 1'b1;
        REG_CHCMD: cmd = pwdata[3:0];
        REG_TDSEL: s_d.tdSel = pwdata[TD_W-1:0];
        REG_TDSRC: wrTdSrc = 1'b1;
        REG_TDDST: wrTdDst = 1'b1;
        REG_TDCTL: wrTdCtl = 1'b1;
        default: cmd = '0;
      endcase
    end
    // winner picked afresh each beat, so preemption lands between beats
    issue = s_q.en && !s_q.rdPend && winValid;
    ctl = tdCtl[ctxTd[w]];
    inf = ctl[TDC_INF];
    bytes = {1'b0, ctl[TDC_WID +: 2]} + 3'h1;
    n = (!inf && ctxRem[w] < REM_W'(bytes)) ? ctxRem[w][2:0] : bytes;
    last = !inf && (ctxRem[w] <= REM_W'(n));
    chainLoad = 1'b0;
    nextTd = ctl[TDC_NEXT +: TD_W];
    chainVec = '0;
    if (issue) begin
      s_d.rdPend = 1'b1;
      s_d.rdAddr = ctxSrc[w];
      s_d.rdDst = ctxDst[w];
      s_d.rdSize = 2'(n - 3'h1);
      s_d.lastCh = w;
      if (last) begin
        s_d.evTd = ctl[TDC_IRQ];
        s_d.evChan = w;
        if (ctl[TDC_CHAIN]) begin
          chainLoad = 1'b1;
        end else begin
          s_d.run[w] = 1'b0;
          s_d.evDone = chCfg[w][CFG_DONE_IRQ];
          if (chCfg[w][CFG_CHAIN_EN]) begin
            chainVec = oneHot(chCfg[w][CFG_CHAIN +: CH_W]);
          end
        end
      end
    end
    if (cmd[CMD_STALL]) begin
      s_d.stall[s_q.chSel] = 1'b1;
    end
    if (cmd[CMD_RESUME]) begin
      s_d.stall[s_q.chSel] = 1'b0;
    end
    if (cmd[CMD_CANCEL]) begin
      s_d.run[s_q.chSel] = 1'b0;
      s_d.stall[s_q.chSel] = 1'b0;
    end
    hwEdge = s_q.trgS2 & ~s_q.trgS3;
    swTrig = cmd[CMD_TRIG] ? oneHot(s_q.chSel) : '0;
    for (int c = 0; c < NUM_CH; c++) begin
      start[c] = chCfg[c][CFG_EN] && !s_q.run[c]
        && (hwEdge[c] || swTrig[c] || chainVec[c]);
    end
    s_d.run = s_d.run | start;
    // hold slot: drain first, then refill from a read or a boot write
    if (wrFire) begin
      s_d.holdFull = 1'b0;
    end
    if (rdFire) begin
      s_d.rdPend = 1'b0;
      s_d.holdFull = 1'b1;
      s_d.wrAddr = s_q.rdDst;
      s_d.wrData = dmaRdData;
      s_d.wrSize = s_q.rdSize;
    end else if (bootWrValid && !s_q.holdFull) begin
      s_d.holdFull = 1'b1;
      s_d.wrAddr = bootWrAddr;
      s_d.wrData = bootWrData;
      s_d.wrSize = SIZE_WORD;
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // ==========================================
  // memories
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      for (int c = 0; c < NUM_CH; c++) begin
        chCfg[c] <= '0;
      end
    end else if (cfgWr) begin
      chCfg[s_q.chSel] <= pwdata[CFG_W-1:0];
    end
  end

  always_ff @(posedge mclk) begin
    if (wrTdSrc) begin
      tdSrc[s_q.tdSel] <= pwdata;
    end
    if (wrTdDst) begin
      tdDst[s_q.tdSel] <= pwdata;
    end
    if (wrTdCtl) begin
      tdCtl[s_q.tdSel] <= pwdata[TDC_W-1:0];
    end
  end

  // start and issue never hit the same channel: start needs it idle
  always_ff @(posedge mclk) begin
    for (int c = 0; c < NUM_CH; c++) begin
      if (start[c]) begin
        ctxTd[c] <= chCfg[c][CFG_TD +: TD_W];
        ctxSrc[c] <= tdSrc[chCfg[c][CFG_TD +: TD_W]];
        ctxDst[c] <= tdDst[chCfg[c][CFG_TD +: TD_W]];
        ctxRem[c] <= remInit(tdCtl[chCfg[c][CFG_TD +: TD_W]]);
      end
    end
    if (issue && chainLoad) begin
      ctxTd[w] <= nextTd;
      ctxSrc[w] <= tdSrc[nextTd];
      ctxDst[w] <= tdDst[nextTd];
      ctxRem[w] <= remInit(tdCtl[nextTd]);
    end else if (issue) begin
      ctxSrc[w] <= ctxSrc[w] + 32'(n);
      ctxDst[w] <= ctxDst[w] + 32'(n);
      if (!inf) begin
        ctxRem[w] <= ctxRem[w] - REM_W'(n);
      end
    end
  end
endmodule
`default_nettype wire

/* sim/dmahub_props.sv */
`timescale 1ns/100ps
`default_nettype none
module dmahub_props import dmahub_pkg::*; (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic cpuReq,
  input wire logic [SPOKE_W-1:0] cpuSpoke,
  input wire logic cpuGnt,
  input wire logic dmaRdValid,
  input wire logic [31:0] dmaRdAddr,
  input wire logic dmaRdReady,
  input wire logic dmaWrValid,
  input wire logic [31:0] dmaWrAddr,
  input wire logic [31:0] dmaWrData,
  input wire logic dmaWrReady,
  input wire logic bootWrReady,
  input wire logic evTdDone,
  input wire logic evChDone
);
  // ==========================================
  // port relations
  default clocking @(posedge mclk); endclocking
  default disable iff (sys_rst);
  cpu_gnt_cause_a: assert property (cpuGnt |-> cpuReq)
    else $error("cpu grant without request");
  rd_spoke_free_a: assert property (
    cpuGnt && dmaRdValid |-> spokeOf(dmaRdAddr) != cpuSpoke)
    else $error("dma read shares the cpu spoke");
  wr_spoke_free_a: assert property (
    cpuGnt && dmaWrValid |-> spokeOf(dmaWrAddr) != cpuSpoke)
    else $error("dma write shares the cpu spoke");
  rd_addr_hold_a: assert property (
    dmaRdValid && !dmaRdReady |=> $stable(dmaRdAddr))
    else $error("read address moved before taken");
  wr_beat_hold_a: assert property (
    dmaWrValid && !dmaWrReady |=> $stable(dmaWrAddr) && $stable(dmaWrData))
    else $error("write beat moved before taken");
  boot_block_a: assert property (dmaWrValid |-> !bootWrReady)
    else $error("boot write accepted while hold busy");
  td_ev_pulse_a: assert property (evTdDone |=> !evTdDone)
    else $error("descriptor event longer than a pulse");
  ch_ev_pulse_a: assert property (evChDone |=> !evChDone)
    else $error("channel event longer than a pulse");
endmodule
bind dmahub_top dmahub_props chk_i (.mclk(mclk), .sys_rst(sys_rst), .cpuReq(cpuReq),
  .cpuSpoke(cpuSpoke), .cpuGnt(cpuGnt), .dmaRdValid(dmaRdValid), .dmaRdAddr(dmaRdAddr),
  .dmaRdReady(dmaRdReady), .dmaWrValid(dmaWrValid), .dmaWrAddr(dmaWrAddr),
  .dmaWrData(dmaWrData), .dmaWrReady(dmaWrReady), .bootWrReady(bootWrReady),
  .evTdDone(evTdDone), .evChDone(evChDone));
`default_nettype wire

/* sim/dmahub_far.sv */
`timescale 1ns/100ps
`default_nettype none
module dmahub_far import dmahub_pkg::*; (
  input wire logic mclk,
  input wire logic slow,
  input wire logic dmaRdValid,
  input wire logic [31:0] dmaRdAddr,
  output logic dmaRdReady,
  output logic [31:0] dmaRdData,
  input wire logic dmaWrValid,
  input wire logic [31:0] dmaWrAddr,
  input wire logic [31:0] dmaWrData,
  output logic dmaWrReady
);
  // ==========================================
  // spoke memories, word per index
  logic [31:0] mem [256];
  logic [1:0] rdWait = 2'h0;
  logic [1:0] wrWait = 2'h0;
  logic [31:0] lastRd = 32'h0000_0000;
  function automatic logic [7:0] idx(input logic [31:0] a);
    return {spokeOf(a), a[6:2]};
  endfunction
  // slow mode makes every beat wait two cycles
  assign dmaRdReady = !slow || rdWait == 2'h2;
  assign dmaWrReady = !slow || wrWait == 2'h2;
  // idle data toggles so a stale value is never mistaken for a beat
  assign dmaRdData = (dmaRdValid && dmaRdReady) ? mem[idx(dmaRdAddr)] : ~lastRd;
  // a waiting beat keeps its count while the hub gates valid off
  always @(posedge mclk) begin
    if (dmaRdValid && dmaRdReady) begin
      rdWait <= 2'h0;
    end else if (dmaRdValid) begin
      rdWait <= rdWait + 2'h1;
    end
    if (dmaWrValid && dmaWrReady) begin
      wrWait <= 2'h0;
    end else if (dmaWrValid) begin
      wrWait <= wrWait + 2'h1;
    end
    lastRd <= dmaRdData;
    if (dmaWrValid && dmaWrReady) begin
      mem[idx(dmaWrAddr)] <= dmaWrData;
    end
  end
endmodule
`default_nettype wire

/* sim/dma_hub_arbiter_test.sv */
`timescale 1ns/100ps
`default_nettype none
module dma_hub_arbiter_test import dmahub_pkg::*; ;
  logic mclk = 1'b0;
  logic sys_rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic cpuReq = 1'b0;
  logic slow = 1'b0;
  logic bootWrValid = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] bootWrAddr = 32'h0000_0000;
  logic [31:0] bootWrData = 32'h0000_0000;
  logic [SPOKE_W-1:0] cpuSpoke = 3'h1;
  logic [NUM_CH-1:0] trigIn = 24'h00_0000;
  logic [31:0] prdata, dmaRdAddr, dmaRdData, dmaWrAddr, dmaWrData, rd;
  logic pready, pslverr, cpuGnt, dmaRdValid, dmaRdReady, dmaWrValid, dmaWrReady;
  logic bootWrReady, evTdDone, evChDone, err;
  logic [1:0] dmaRdSize, dmaWrSize;
  logic [CH_W-1:0] evChan;
  int fails = 0;
  int cmp_count = 0;

  dmahub_top dut (.mclk(mclk), .sys_rst(sys_rst), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .cpuReq(cpuReq), .cpuSpoke(cpuSpoke), .cpuGnt(cpuGnt),
    .dmaRdValid(dmaRdValid), .dmaRdAddr(dmaRdAddr), .dmaRdSize(dmaRdSize),
    .dmaRdReady(dmaRdReady), .dmaRdData(dmaRdData), .dmaWrValid(dmaWrValid),
    .dmaWrAddr(dmaWrAddr), .dmaWrSize(dmaWrSize), .dmaWrData(dmaWrData),
    .dmaWrReady(dmaWrReady), .bootWrValid(bootWrValid), .bootWrAddr(bootWrAddr),
    .bootWrData(bootWrData), .bootWrReady(bootWrReady), .trigIn(trigIn),
    .evTdDone(evTdDone), .evChDone(evChDone), .evChan(evChan));
  dmahub_far far (.mclk(mclk), .slow(slow), .dmaRdValid(dmaRdValid), .dmaRdAddr(dmaRdAddr),
    .dmaRdReady(dmaRdReady), .dmaRdData(dmaRdData), .dmaWrValid(dmaWrValid),
    .dmaWrAddr(dmaWrAddr), .dmaWrData(dmaWrData), .dmaWrReady(dmaWrReady));

  // ==========================================
  // shared tasks
  task end_sim;
    if (fails == 0 && cmp_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      $display("BAD %s exp %h got %h", n, e, g);
      fails++;
    end
  endtask
  // entered just after a rising edge; leaves one idle edge behind
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      fails++;
      end_sim;
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge mclk);
  endtask
  task td(input logic [31:0] i, input logic [31:0] s, input logic [31:0] d,
          input logic [31:0] c);
    apb(1'b1, REG_TDSEL, i);
    apb(1'b1, REG_TDSRC, s);
    apb(1'b1, REG_TDDST, d);
    apb(1'b1, REG_TDCTL, c);
  endtask
  task chan(input logic [31:0] c, input logic [31:0] cfg, input logic [31:0] cmd);
    apb(1'b1, REG_CHSEL, c);
    apb(1'b1, REG_CHCFG, cfg);
    if (cmd != 0) apb(1'b1, REG_CHCMD, cmd);
  endtask
  task wait_done(input logic [CH_W-1:0] ch);
    int n;
    n = 0;
    do begin
      @(negedge mclk);
      n++;
    end while (evChDone !== 1'b1 && n < 2000);
    if (n >= 2000) begin
      fails++;
      end_sim;
    end
    chk("evChan", 32'(ch), 32'(evChan));
    @(posedge mclk);
  endtask
  // the done event leads the last write: wait for the hold slot to empty
  task drain;
    int n;
    n = 0;
    do begin
      apb(1'b0, REG_STATUS, 32'h0000_0000);
      n++;
    end while (rd[3:2] !== 2'b00 && n < 50);
    chk("drained", 32'h0000_0000, {30'h0, rd[3:2]});
  endtask

  // ==========================================
  // scenarios
  task regs_boot;
    apb(1'b0, REG_CTRL, 32'h0000_0000);
    chk("ctrl reset", 32'h0000_0000, rd);
    apb(1'b0, 12'h024, 32'h0000_0000);
    chk("unmapped err", 32'h0000_0001, {31'h0, err});
    apb(1'b1, REG_CTRL, 32'h0000_0001);
    bootWrAddr <= 32'h6000_0010;
    bootWrData <= 32'hB007_0001;
    bootWrValid <= 1'b1;
    @(posedge mclk);
    bootWrValid <= 1'b0;
    apb(1'b0, REG_STATUS, 32'h0000_0000);
    chk("status en", 32'h0000_0001, rd & 32'h0000_0003);
    chk("boot write", 32'hB007_0001, far.mem[8'h64]);
  endtask
  task simple_copy;
    far.mem[8'h04] = 32'hA5A5_0001;
    far.mem[8'h05] = 32'h5A5A_0002;
    td(0, 32'h0000_0010, 32'h2000_0020, 32'h0E00_0007);
    chan(0, 32'h0004_0800, 32'h0000_0001);
    wait_done(5'd0);
    drain;
    chk("copy w0", 32'hA5A5_0001, far.mem[8'h28]);
    chk("copy w1", 32'h5A5A_0002, far.mem[8'h29]);
  endtask
  // cpu parked on the sink spoke for the whole run, slow far side
  task cpu_contention;
    far.mem[8'h10] = 32'hC0DE_0023;
    slow <= 1'b1;
    cpuReq <= 1'b1;
    td(127, 32'h0000_0040, 32'h2000_0044, 32'h0C00_0003);
    chan(23, 32'h0004_0FF2, 32'h0000_0000);
    chk("cpu grant", 32'h0000_0001, {31'h0, cpuGnt});
    trigIn[23] <= 1'b1;
    wait_done(5'd23);
    drain;
    chk("last channel", 32'hC0DE_0023, far.mem[8'h31]);
    trigIn[23] <= 1'b0;
    cpuReq <= 1'b0;
    slow <= 1'b0;
  endtask
  task prio_order;
    far.mem[8'h14] = 32'h0000_0555;
    far.mem[8'h15] = 32'h0000_0666;
    td(5, 32'h0000_0050, 32'h2000_0050, 32'h0C00_0003);
    td(6, 32'h0000_0054, 32'h2000_0054, 32'h0C00_0003);
    chan(5, 32'h0004_0853, 32'h0000_0000);
    chan(6, 32'h0004_0861, 32'h0000_0000);
    trigIn[6:5] <= 2'b11;
    wait_done(5'd6);
    wait_done(5'd5);
    drain;
    chk("prio data", 32'h0000_0555, far.mem[8'h34]);
    trigIn[6:5] <= 2'b00;
  endtask
  // fairness on, two channels tie at level 2, one opted out of round robin
  task rr_fair;
    far.mem[8'h18] = 32'h0000_0777;
    apb(1'b1, REG_CTRL, 32'h0000_0003);
    apb(1'b0, REG_CTRL, 32'h0000_0000);
    chk("fair on", 32'h0000_0003, rd);
    td(7, 32'h0000_0060, 32'h2000_0060, 32'h0C00_0003);
    td(8, 32'h0000_0060, 32'h2000_0064, 32'h0400_0001);
    chan(7, 32'h0004_0872, 32'h0000_0000);
    chan(8, 32'h0004_088A, 32'h0000_0000);
    trigIn[8:7] <= 2'b11;
    wait_done(5'd8);
    wait_done(5'd7);
    drain;
    chk("half word", 32'h0000_0777, far.mem[8'h39]);
    chk("rr word", 32'h0000_0777, far.mem[8'h38]);
    trigIn[8:7] <= 2'b00;
  endtask
  task stall_cancel;
    int n;
    td(4, 32'h6000_0000, 32'h8000_0000, 32'h0C01_0000);
    chan(4, 32'h0000_0844, 32'h0000_0001);
    apb(1'b1, REG_CHCMD, 32'h0000_0002);
    apb(1'b0, REG_CHCFG, 32'h0000_0000);
    chk("stalled", 32'h0000_0003, {30'h0, rd[ST_STALL], rd[ST_RUN]});
    apb(1'b1, REG_CHCMD, 32'h0000_0004);
    apb(1'b0, REG_CHCFG, 32'h0000_0000);
    chk("resumed", 32'h0000_0001, {30'h0, rd[ST_STALL], rd[ST_RUN]});
    apb(1'b1, REG_CHCMD, 32'h0000_0008);
    n = 0;
    do begin
      apb(1'b0, REG_CHCFG, 32'h0000_0000);
      n++;
    end while (rd[ST_RUN] !== 1'b0 && n < 20);
    chk("cancelled", 32'h0000_0000, {31'h0, rd[ST_RUN]});
  endtask

  initial begin
    forever #2.5 mclk = ~mclk;
  end
  initial begin
    repeat (16) @(posedge mclk);
    sys_rst <= 1'b0;
    @(posedge mclk);
    regs_boot;
    simple_copy;
    cpu_contention;
    prio_order;
    rr_fair;
    stall_cancel;
    end_sim;
  end
endmodule
`default_nettype wire
